/* File: hw/t0ci_defs.vh */
`ifndef T0CI_DEFS_VH
`define T0CI_DEFS_VH

// ****************************************************************
// Register addresses on the I/O bus
// ****************************************************************
`define T0CI_ADR_CNT_H 6'h14
`define T0CI_ADR_CTRL_A 6'h15
`define T0CI_ADR_CTRL_B 6'h33
`define T0CI_ADR_FLAGS 6'h38
`define T0CI_ADR_MASK 6'h39
`define T0CI_ADR_CNT_L 6'h32
`define T0CI_ADR_CMP_A 6'h13
`define T0CI_ADR_CMP_B 6'h12

// ****************************************************************
// Field positions
// ****************************************************************
`define T0CI_BIT_WIDTH 7
`define T0CI_BIT_CTC 0
`define T0CI_BIT_TSM 4
`define T0CI_BIT_PSR 3
`define T0CI_BIT_CA 4
`define T0CI_BIT_CB 3
`define T0CI_BIT_OV 1
`define T0CI_BIT_IC 0

// ****************************************************************
// Writable masks and reset values
// ****************************************************************
`define T0CI_WMASK_CTRL_A 8'hf9
`define T0CI_WMASK_CTRL_B 8'h1f
`define T0CI_WMASK_IRQ 8'h1b
`define T0CI_RST_BYTE 8'h00
`define T0CI_RST_WORD 16'h0000

// ****************************************************************
// Clock select codes
// ****************************************************************
`define T0CI_CS_STOP 3'h0
`define T0CI_CS_DIV1 3'h1
`define T0CI_CS_DIV8 3'h2
`define T0CI_CS_DIV64 3'h3
`define T0CI_CS_DIV256 3'h4
`define T0CI_CS_DIV1024 3'h5
`define T0CI_CS_EXT_FALL 3'h6
`define T0CI_CS_EXT_RISE 3'h7

// ****************************************************************
// Prescaler tap widths (divide by two to the power of the tap)
// ****************************************************************
`define T0CI_TAP8 3
`define T0CI_TAP64 6
`define T0CI_TAP256 8
`define T0CI_TAP1024 10

// ****************************************************************
// Counter limits
// ****************************************************************
`define T0CI_MAX8 16'h00ff
`define T0CI_MAX16 16'hffff
`define T0CI_ONE16 16'h0001

`endif

/* File: hw/t0ci_prescaler.v */
`timescale 1ns/100ps
`include "t0ci_defs.vh"

module t0ci_prescaler #(
    parameter PRE_W = 10
) (
    input wire clk_i,
    input wire srst_i,
    input wire clear_i,
    output wire tick8_o,
    output wire tick64_o,
    output wire tick256_o,
    output wire tick1024_o
);
    reg [PRE_W-1:0] count;

    // Free-running divider, held at zero while cleared
    always @(posedge clk_i) begin
        if (srst_i || clear_i) begin
            count <= {PRE_W{1'b0}};
        end else begin
            count <= count + {{(PRE_W-1){1'b0}}, 1'b1};
        end
    end

    // One-cycle enables when the low bits roll over
    assign tick8_o = &count[`T0CI_TAP8-1:0];
    assign tick64_o = &count[`T0CI_TAP64-1:0];
    assign tick256_o = &count[`T0CI_TAP256-1:0];
    assign tick1024_o = &count[`T0CI_TAP1024-1:0];
endmodule // t0ci_prescaler

/* File: hw/t0ci_edge.v */
`timescale 1ns/100ps

module t0ci_edge (
    input wire clk_i,
    input wire srst_i,
    input wire pin_i,
    output wire rise_o,
    output wire fall_o
);
    reg pin_q;

    // Previous pin level, pin already synchronous
    always @(posedge clk_i) begin
        if (srst_i) begin
            pin_q <= 1'b0;
        end else begin
            pin_q <= pin_i;
        end
    end

    assign rise_o = pin_i & ~pin_q;
    assign fall_o = ~pin_i & pin_q;
endmodule // t0ci_edge

/* File: hw/t0ci_top.v */
`timescale 1ns/100ps
`include "t0ci_defs.vh"

module t0ci_top #(
    parameter PRE_W = 10
) (
    input wire clk_i,
    input wire srst_i,
    input wire [5:0] addr_i,
    input wire [7:0] wdata_i,
    input wire we_i,
    input wire re_i,
    output reg [7:0] rdata_o,
    input wire ext_pin_i,
    input wire capture_evt_i,
    input wire gie_i,
    input wire ack_cmp_a_i,
    input wire ack_cmp_b_i,
    input wire ack_ovf_i,
    input wire ack_cap_i,
    output wire irq_cmp_a_o,
    output wire irq_cmp_b_o,
    output wire irq_ovf_o,
    output wire irq_cap_o
);
    // ****************************************************************
    // State
    // ****************************************************************
    reg [7:0] ctrl_a;
    reg sync_halt_mode;
    reg prescaler_reset_bit;
    reg [2:0] clock_select;
    reg [15:0] counter;
    reg [7:0] compare_a_value;
    reg [7:0] compare_b_value;
    reg [7:0] temp_high;
    reg [7:0] irq_mask;
    reg [7:0] irq_flags;
    reg match_block;

    wire wide;
    wire clear_on_match_mode;
    wire tick8, tick64, tick256, tick1024;
    wire ext_rise, ext_fall;
    reg src_tick;
    wire tick;
    wire wr_cnt_l, wr_cnt_h, wr_cmp_a, wr_cmp_b;
    wire wr_ctrl_a, wr_ctrl_b, wr_flags, wr_mask;
    wire rd_cnt_l, rd_cnt_h;
    wire [15:0] compare_word;
    wire [15:0] top_value;
    wire at_top, match_a, match_b;
    reg [15:0] next_counter;
    reg [7:0] next_flags;
    reg [7:0] flag_set;
    reg [7:0] flag_clr;
    reg [7:0] next_rdata;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Address strobe
    function hit;
        input [5:0] a;
        input [5:0] ref_a;
        begin
            hit = (a == ref_a);
        end
    endfunction

    // Equality at the active width
    function eq_w;
        input w;
        input [15:0] x;
        input [15:0] y;
        begin
            eq_w = w ? (x == y) : (x[7:0] == y[7:0]);
        end
    endfunction

    assign wide = ctrl_a[`T0CI_BIT_WIDTH];
    assign clear_on_match_mode = ctrl_a[`T0CI_BIT_CTC];

    assign wr_cnt_l = we_i & hit(addr_i, `T0CI_ADR_CNT_L);
    assign wr_cnt_h = we_i & hit(addr_i, `T0CI_ADR_CNT_H);
    assign wr_cmp_a = we_i & hit(addr_i, `T0CI_ADR_CMP_A);
    assign wr_cmp_b = we_i & hit(addr_i, `T0CI_ADR_CMP_B);
    assign wr_ctrl_a = we_i & hit(addr_i, `T0CI_ADR_CTRL_A);
    assign wr_ctrl_b = we_i & hit(addr_i, `T0CI_ADR_CTRL_B);
    assign wr_flags = we_i & hit(addr_i, `T0CI_ADR_FLAGS);
    assign wr_mask = we_i & hit(addr_i, `T0CI_ADR_MASK);
    assign rd_cnt_l = re_i & hit(addr_i, `T0CI_ADR_CNT_L);
    assign rd_cnt_h = re_i & hit(addr_i, `T0CI_ADR_CNT_H);

    // ****************************************************************
    // Clock sources
    // ****************************************************************
    t0ci_prescaler #(
        .PRE_W(PRE_W)
    ) u_pre (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .clear_i(prescaler_reset_bit),
        .tick8_o(tick8),
        .tick64_o(tick64),
        .tick256_o(tick256),
        .tick1024_o(tick1024)
    );

    t0ci_edge u_edge (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .pin_i(ext_pin_i),
        .rise_o(ext_rise),
        .fall_o(ext_fall)
    );

    // Clock select decode
    always @* begin
        case (clock_select)
            `T0CI_CS_STOP: src_tick = 1'b0;
            `T0CI_CS_DIV1: src_tick = 1'b1;
            `T0CI_CS_DIV8: src_tick = tick8;
            `T0CI_CS_DIV64: src_tick = tick64;
            `T0CI_CS_DIV256: src_tick = tick256;
            `T0CI_CS_DIV1024: src_tick = tick1024;
            `T0CI_CS_EXT_FALL: src_tick = ext_fall;
            `T0CI_CS_EXT_RISE: src_tick = ext_rise;
            default: src_tick = 1'b0;
        endcase
    end

    // Held prescaler reset halts every source
    assign tick = src_tick & ~prescaler_reset_bit;

    // ****************************************************************
    // Compare and top
    // ****************************************************************
    assign compare_word = {compare_b_value, compare_a_value};
    assign top_value = clear_on_match_mode ? (wide ? compare_word :
        {8'h00, compare_a_value}) : (wide ? `T0CI_MAX16 : `T0CI_MAX8);
    assign at_top = eq_w(wide, counter, top_value);
    assign match_a = eq_w(wide, counter, compare_word);
    assign match_b = wide ? (counter[15:8] == compare_b_value) :
        (counter[7:0] == compare_b_value);

    // Counter next value, bus writes take priority
    always @* begin
        next_counter = counter;
        if (wr_cnt_l) begin
            if (wide) begin
                next_counter = {temp_high, wdata_i};
            end else begin
                next_counter = {counter[15:8], wdata_i};
            end
        end else if (wr_cnt_h && !wide) begin
            next_counter = {wdata_i, counter[7:0]};
        end else if (tick) begin
            if (at_top) begin
                next_counter = wide ? `T0CI_RST_WORD :
                    {counter[15:8], 8'h00};
            end else if (wide) begin
                next_counter = counter + `T0CI_ONE16;
            end else begin
                next_counter = {counter[15:8],
                    counter[7:0] + 8'h01};
            end
        end
    end

    // ****************************************************************
    // Flags
    // ****************************************************************
    // Set wins over a clear in the same cycle
    always @* begin
        flag_set = `T0CI_RST_BYTE;
        flag_clr = `T0CI_RST_BYTE;
        if (tick && !match_block) begin
            flag_set[`T0CI_BIT_CA] = match_a;
            flag_set[`T0CI_BIT_CB] = match_b;
        end
        flag_set[`T0CI_BIT_OV] = tick & at_top & ~clear_on_match_mode;
        flag_set[`T0CI_BIT_IC] = capture_evt_i;
        if (wr_flags) begin
            flag_clr = wdata_i & `T0CI_WMASK_IRQ;
        end
        flag_clr[`T0CI_BIT_CA] = flag_clr[`T0CI_BIT_CA] | ack_cmp_a_i;
        flag_clr[`T0CI_BIT_CB] = flag_clr[`T0CI_BIT_CB] | ack_cmp_b_i;
        flag_clr[`T0CI_BIT_OV] = flag_clr[`T0CI_BIT_OV] | ack_ovf_i;
        flag_clr[`T0CI_BIT_IC] = flag_clr[`T0CI_BIT_IC] | ack_cap_i;
        next_flags = ((irq_flags & ~flag_clr) | flag_set) &
            `T0CI_WMASK_IRQ;
    end

    // ****************************************************************
    // Read mux
    // ****************************************************************
    always @* begin
        case (addr_i)
            `T0CI_ADR_CNT_L: next_rdata = counter[7:0];
            `T0CI_ADR_CNT_H: next_rdata = wide ? temp_high :
                counter[15:8];
            `T0CI_ADR_CMP_A: next_rdata = compare_a_value;
            `T0CI_ADR_CMP_B: next_rdata = compare_b_value;
            `T0CI_ADR_CTRL_A: next_rdata = ctrl_a;
            `T0CI_ADR_CTRL_B: next_rdata = {3'h0, sync_halt_mode,
                prescaler_reset_bit, clock_select};
            `T0CI_ADR_FLAGS: next_rdata = irq_flags;
            `T0CI_ADR_MASK: next_rdata = irq_mask;
            default: next_rdata = `T0CI_RST_BYTE;
        endcase
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always @(posedge clk_i) begin
        if (srst_i) begin
            ctrl_a <= `T0CI_RST_BYTE;
            sync_halt_mode <= 1'b0;
            prescaler_reset_bit <= 1'b0;
            clock_select <= `T0CI_CS_STOP;
            counter <= `T0CI_RST_WORD;
            compare_a_value <= `T0CI_RST_BYTE;
            compare_b_value <= `T0CI_RST_BYTE;
            temp_high <= `T0CI_RST_BYTE;
            irq_mask <= `T0CI_RST_BYTE;
            irq_flags <= `T0CI_RST_BYTE;
            match_block <= 1'b0;
            rdata_o <= `T0CI_RST_BYTE;
        end else begin
            counter <= next_counter;
            irq_flags <= next_flags;
            // Block lasts until the next timer clock
            if (wr_cnt_l) begin
                match_block <= 1'b1;
            end else if (tick) begin
                match_block <= 1'b0;
            end
            if (wr_ctrl_a) begin
                ctrl_a <= wdata_i & `T0CI_WMASK_CTRL_A;
            end
            // Control B: sync mode and prescaler reset
            if (wr_ctrl_b) begin
                sync_halt_mode <= wdata_i[`T0CI_BIT_TSM];
                prescaler_reset_bit <= wdata_i[`T0CI_BIT_PSR] &
                    wdata_i[`T0CI_BIT_TSM] |
                    wdata_i[`T0CI_BIT_PSR] & ~wdata_i[`T0CI_BIT_TSM] &
                    ~sync_halt_mode;
                clock_select <= wdata_i[2:0];
            end else if (!sync_halt_mode) begin
                prescaler_reset_bit <= 1'b0;
            end
            // Shared temp byte for wide accesses
            if (wide && (wr_cnt_h || wr_cmp_b)) begin
                temp_high <= wdata_i;
            end else if (wide && rd_cnt_l) begin
                temp_high <= counter[15:8];
            end
            if (wr_cmp_a) begin
                compare_a_value <= wdata_i;
                if (wide) begin
                    compare_b_value <= temp_high;
                end
            end else if (wr_cmp_b && !wide) begin
                compare_b_value <= wdata_i;
            end
            if (wr_mask) begin
                irq_mask <= wdata_i & `T0CI_WMASK_IRQ;
            end
            if (re_i) begin
                rdata_o <= next_rdata;
            end
        end
    end

    // ****************************************************************
    // Interrupt requests
    // ****************************************************************
    assign irq_cmp_a_o = gie_i & irq_mask[`T0CI_BIT_CA] &
        irq_flags[`T0CI_BIT_CA];
    assign irq_cmp_b_o = gie_i & irq_mask[`T0CI_BIT_CB] &
        irq_flags[`T0CI_BIT_CB];
    assign irq_ovf_o = gie_i & irq_mask[`T0CI_BIT_OV] &
        irq_flags[`T0CI_BIT_OV];
    assign irq_cap_o = gie_i & irq_mask[`T0CI_BIT_IC] &
        irq_flags[`T0CI_BIT_IC];
endmodule // t0ci_top

/* File: testbench/t0ci_monitor.sv */
`timescale 1ns/100ps
`include "t0ci_defs.vh"
// ****************************************
// Bus and interrupt checker
// ****************************************
module t0ci_monitor (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic [5:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic we_i,
    input wire logic re_i,
    input wire logic [7:0] rdata_o,
    input wire logic capture_evt_i,
    input wire logic gie_i,
    input wire logic ack_cap_i,
    input wire logic irq_cmp_a_o,
    input wire logic irq_cmp_b_o,
    input wire logic irq_ovf_o,
    input wire logic irq_cap_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (srst_i);
    // Control and mask accesses
    sequence s_ctl_wr(logic [1:0] v);
        we_i && addr_i == `T0CI_ADR_CTRL_B && wdata_i[4:3] == v;
    endsequence
    sequence s_ctl_rd;
        re_i && !we_i && addr_i == `T0CI_ADR_CTRL_B;
    endsequence
    sequence s_mask_wr;
        we_i && addr_i == `T0CI_ADR_MASK;
    endsequence
    sequence s_mask_rd;
        !we_i ##1 (re_i && !we_i && addr_i == `T0CI_ADR_MASK);
    endsequence
    AST_IRQ_CA: assert property (irq_cmp_a_o |-> gie_i)
        else $error("compare A request without global enable");
    AST_IRQ_CB: assert property (!gie_i |-> !irq_cmp_b_o)
        else $error("compare B request without global enable");
    AST_IRQ_OV: assert property ($rose(irq_ovf_o) |-> gie_i)
        else $error("overflow request without global enable");
    AST_IRQ_CAP: assert property (irq_cap_o |-> gie_i)
        else $error("capture request without global enable");
    AST_CAP_ACK: assert property (
        ack_cap_i && !capture_evt_i |=> !irq_cap_o)
        else $error("capture request kept after vector");
    AST_CAP_W1C: assert property (
        we_i && addr_i == `T0CI_ADR_FLAGS && wdata_i[`T0CI_BIT_IC]
        && !capture_evt_i |=> !irq_cap_o)
        else $error("capture request kept after write one");
    AST_PSR_HOLD: assert property (
        s_ctl_wr(2'h3) ##1 (!we_i)[*2] ##1 s_ctl_rd
        |=> rdata_o[4:3] == 2'h3)
        else $error("prescaler reset not held in sync mode");
    AST_PSR_PULSE: assert property (
        s_ctl_wr(2'h1) ##1 (!we_i)[*2] ##1 s_ctl_rd |=> !rdata_o[3])
        else $error("prescaler reset did not clear itself");
    AST_MASK_RB: assert property (
        s_mask_wr ##1 s_mask_rd
        |=> rdata_o == ($past(wdata_i, 3) & `T0CI_WMASK_IRQ))
        else $error("mask read back wrong");
    AST_RD_HOLD: assert property (!re_i |=> $stable(rdata_o))
        else $error("read data moved without a read");
endmodule // t0ci_monitor

bind t0ci_top t0ci_monitor u_mon (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .we_i(we_i),
    .re_i(re_i),
    .rdata_o(rdata_o),
    .capture_evt_i(capture_evt_i),
    .gie_i(gie_i),
    .ack_cap_i(ack_cap_i),
    .irq_cmp_a_o(irq_cmp_a_o),
    .irq_cmp_b_o(irq_cmp_b_o),
    .irq_ovf_o(irq_ovf_o),
    .irq_cap_o(irq_cap_o)
);

/* File: testbench/t0ci_cpu_model.sv */
`timescale 1ns/100ps
// ****************************************
// CPU side of the register bus
// ****************************************
module t0ci_cpu_model (
    input wire logic clk_i,
    input wire logic [7:0] rdata_i,
    output logic [5:0] addr_o,
    output logic [7:0] wdata_o,
    output logic we_o,
    output logic re_o
);
    // Idle bus at time zero
    initial begin
        addr_o = 6'h00;
        wdata_o = 8'h00;
        we_o = 1'h0;
        re_o = 1'h0;
    end
    // One write pulse; data lines scrambled once released
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= d;
        we_o <= 1'h1;
        @(posedge clk_i);
        we_o <= 1'h0;
        wdata_o <= ~d;
    endtask
    // One read pulse; data taken after the answering edge
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        re_o <= 1'h1;
        @(posedge clk_i);
        re_o <= 1'h0;
        #1;
        d = rdata_i;
    endtask
    // Wide write, high byte first so the low byte commits both
    task automatic wr16(input logic [5:0] ah, input logic [5:0] al,
                        input logic [15:0] v);
        wr(ah, v[15:8]);
        wr(al, v[7:0]);
    endtask
    // Wide read, low byte first so the high byte is caught with it
    task automatic rd16(input logic [5:0] al, input logic [5:0] ah,
                        output logic [15:0] v);
        logic [7:0] lo;
        logic [7:0] hi;
        rd(al, lo);
        rd(ah, hi);
        v = {hi, lo};
    endtask
endmodule // t0ci_cpu_model

/* File: testbench/tb_timer0_control_and_interrupts.sv */
`timescale 1ns/100ps
`include "t0ci_defs.vh"
// ****************************************
// Timer control and interrupt bench
// ****************************************
module tb_timer0_control_and_interrupts;
    logic clk_i = 1'h0;
    logic srst_i = 1'h1;
    logic ext_pin = 1'h0;
    logic gie = 1'h0;
    logic [4:0] ev = 5'h00;
    wire [5:0] addr;
    wire [7:0] wdata;
    wire [7:0] rdata;
    wire we;
    wire re;
    wire irq_a;
    wire irq_b;
    wire irq_ov;
    wire irq_cp;
    int failures = 0;
    int num_checks = 0;
    localparam logic [5:0] reg_list [8] = '{`T0CI_ADR_CNT_H,
        `T0CI_ADR_CTRL_A, `T0CI_ADR_CTRL_B, `T0CI_ADR_FLAGS,
        `T0CI_ADR_MASK, `T0CI_ADR_CNT_L, `T0CI_ADR_CMP_A, `T0CI_ADR_CMP_B};
    // Clock, 4 ns period
    always #2 clk_i = ~clk_i;
    t0ci_top #(.PRE_W(10)) DUT (.clk_i(clk_i), .srst_i(srst_i),
        .addr_i(addr), .wdata_i(wdata), .we_i(we), .re_i(re),
        .rdata_o(rdata), .ext_pin_i(ext_pin), .capture_evt_i(ev[4]),
        .gie_i(gie), .ack_cmp_a_i(ev[0]), .ack_cmp_b_i(ev[1]),
        .ack_ovf_i(ev[2]), .ack_cap_i(ev[3]), .irq_cmp_a_o(irq_a),
        .irq_cmp_b_o(irq_b), .irq_ovf_o(irq_ov), .irq_cap_o(irq_cp));
    t0ci_cpu_model cpu (.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr),
        .wdata_o(wdata), .we_o(we), .re_o(re));
    // Compare and count
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // One-cycle pulse on acks and capture event
    task automatic pulse(input logic [4:0] m);
        @(posedge clk_i);
        ev <= m;
        @(posedge clk_i);
        ev <= 5'h00;
        #1;
    endtask
    task automatic t_regs();
        logic [7:0] d;
        foreach (reg_list[i]) begin
            cpu.rd(reg_list[i], d);
            chk(d, 8'h00);
        end
        cpu.wr(`T0CI_ADR_MASK, 8'hff);
        cpu.rd(`T0CI_ADR_MASK, d);
        chk(d, `T0CI_WMASK_IRQ);
        cpu.wr(6'h3f, 8'hff);
        cpu.rd(6'h3f, d);
        chk(d, 8'h00);
        cpu.wr(`T0CI_ADR_CTRL_B, 8'he0);
        cpu.rd(`T0CI_ADR_CTRL_B, d);
        chk(d, 8'h00);
        cpu.wr(`T0CI_ADR_MASK, 8'h00);
    endtask
    task automatic t_sync();
        logic [7:0] d;
        cpu.wr(`T0CI_ADR_CNT_L, 8'h00);
        cpu.wr(`T0CI_ADR_CTRL_B, 8'h19);
        idle(1);
        cpu.rd(`T0CI_ADR_CTRL_B, d);
        chk(d, 8'h19);
        idle(20);
        cpu.rd(`T0CI_ADR_CNT_L, d);
        chk(d, 8'h00);
        // Leaving sync mode with reset written high must not keep it
        cpu.wr(`T0CI_ADR_CTRL_B, 8'h09);
        idle(1);
        cpu.rd(`T0CI_ADR_CTRL_B, d);
        chk(d, 8'h01);
        cpu.rd(`T0CI_ADR_CNT_L, d);
        chk(d != 8'h00, 1'h1);
        cpu.wr(`T0CI_ADR_CTRL_B, 8'h08);
        idle(1);
        cpu.rd(`T0CI_ADR_CTRL_B, d);
        chk(d, 8'h00);
    endtask
    task automatic t_sel();
        logic [7:0] d;
        int n;
        for (int i = 1; i <= 5; i++) begin
            n = (i == 2) ? 8 : (i == 3) ? 64 : (i == 4) ? 256 : 1024;
            cpu.wr(`T0CI_ADR_CNT_L, 8'h00);
            cpu.wr(`T0CI_ADR_CTRL_B, 8'h08 | 8'(i));
            idle((i == 1) ? 40 : 3 * n + n / 2);
            cpu.wr(`T0CI_ADR_CTRL_B, 8'h00);
            cpu.rd(`T0CI_ADR_CNT_L, d);
            if (i == 1)
                chk(d >= 8'h26 && d <= 8'h2c, 1'h1);
            else
                chk(d, 8'h03);
        end
        cpu.wr(`T0CI_ADR_CNT_L, 8'h77);
        idle(20);
        cpu.rd(`T0CI_ADR_CNT_L, d);
        chk(d, 8'h77);
    endtask
    // Pin ends high: four rises, three falls
    task automatic t_ext();
        logic [7:0] d;
        for (int m = 6; m <= 7; m++) begin
            @(posedge clk_i);
            ext_pin <= 1'h0;
            cpu.wr(`T0CI_ADR_CNT_L, 8'h00);
            cpu.wr(`T0CI_ADR_CTRL_B, 8'(m));
            repeat (7) begin
                @(posedge clk_i);
                ext_pin <= ~ext_pin;
                idle(3);
            end
            cpu.wr(`T0CI_ADR_CTRL_B, 8'h00);
            cpu.rd(`T0CI_ADR_CNT_L, d);
            chk(d, (m == 6) ? 8'h03 : 8'h04);
        end
    endtask
    task automatic t_cmp();
        cpu.wr(`T0CI_ADR_FLAGS, 8'h1b);
        cpu.wr(`T0CI_ADR_CMP_A, 8'h05);
        cpu.wr(`T0CI_ADR_CMP_B, 8'h09);
        cpu.wr(`T0CI_ADR_MASK, 8'h1a);
        cpu.wr(`T0CI_ADR_CNT_L, 8'h00);
        cpu.wr(`T0CI_ADR_CTRL_B, 8'h01);
        idle(20);
        cpu.wr(`T0CI_ADR_CTRL_B, 8'h00);
        chk({irq_a, irq_b}, 2'h0);
        @(posedge clk_i);
        gie <= 1'h1;
        #1;
        chk({irq_a, irq_b}, 2'h3);
        pulse(5'h01);
        chk({irq_a, irq_b}, 2'h1);
        cpu.wr(`T0CI_ADR_FLAGS, 8'h08);
        #1;
        chk(irq_b, 1'h0);
        cpu.wr(`T0CI_ADR_CTRL_B, 8'h01);
        cpu.wr(`T0CI_ADR_CNT_L, 8'h05);
        idle(10);
        cpu.wr(`T0CI_ADR_CTRL_B, 8'h00);
        chk({irq_a, irq_b}, 2'h1);
    endtask
    task automatic t_ctc();
        logic [7:0] d;
        cpu.wr(`T0CI_ADR_FLAGS, 8'h1b);
        cpu.wr(`T0CI_ADR_CTRL_A, 8'h01);
        cpu.wr(`T0CI_ADR_CMP_A, 8'h10);
        cpu.wr(`T0CI_ADR_CNT_L, 8'h00);
        cpu.wr(`T0CI_ADR_CTRL_B, 8'h01);
        idle(100);
        cpu.wr(`T0CI_ADR_CTRL_B, 8'h00);
        cpu.rd(`T0CI_ADR_CNT_L, d);
        chk(d <= 8'h10, 1'h1);
        cpu.rd(`T0CI_ADR_FLAGS, d);
        chk({d[4], d[1]}, 2'h2);
        cpu.wr(`T0CI_ADR_CTRL_A, 8'h00);
        cpu.wr(`T0CI_ADR_CNT_L, 8'hf0);
        cpu.wr(`T0CI_ADR_CTRL_B, 8'h01);
        idle(30);
        cpu.wr(`T0CI_ADR_CTRL_B, 8'h00);
        chk(irq_ov, 1'h1);
        pulse(5'h04);
        cpu.rd(`T0CI_ADR_FLAGS, d);
        chk(d[1], 1'h0);
    endtask
    task automatic t_wide();
        logic [15:0] v;
        logic [7:0] d;
        cpu.wr(`T0CI_ADR_CTRL_A, 8'h80);
        cpu.wr(`T0CI_ADR_FLAGS, 8'h1b);
        cpu.wr16(`T0CI_ADR_CNT_H, `T0CI_ADR_CNT_L, 16'h01ff);
        cpu.rd16(`T0CI_ADR_CNT_L, `T0CI_ADR_CNT_H, v);
        chk(v, 16'h01ff);
        cpu.wr16(`T0CI_ADR_CMP_B, `T0CI_ADR_CMP_A, 16'h0105);
        cpu.wr(`T0CI_ADR_CNT_L, 8'h00);
        cpu.rd16(`T0CI_ADR_CNT_L, `T0CI_ADR_CNT_H, v);
        chk(v, 16'h0100);
        cpu.wr(`T0CI_ADR_CTRL_B, 8'h01);
        idle(20);
        cpu.wr(`T0CI_ADR_CTRL_B, 8'h00);
        cpu.rd(`T0CI_ADR_FLAGS, d);
        chk(d[4], 1'h1);
        cpu.wr(`T0CI_ADR_FLAGS, 8'h1b);
        cpu.wr16(`T0CI_ADR_CNT_H, `T0CI_ADR_CNT_L, 16'hfff0);
        cpu.wr(`T0CI_ADR_CTRL_B, 8'h01);
        idle(30);
        cpu.wr(`T0CI_ADR_CTRL_B, 8'h00);
        cpu.rd16(`T0CI_ADR_CNT_L, `T0CI_ADR_CNT_H, v);
        chk(v < 16'h0030, 1'h1);
        chk(irq_ov, 1'h1);
        // Low byte passes 01 after the wrap; B must watch the high byte
        cpu.rd(`T0CI_ADR_FLAGS, d);
        chk(d[3], 1'h0);
        // Wide clear-on-match: top is the joined compare word 0105
        cpu.wr(`T0CI_ADR_CTRL_A, 8'h81);
        cpu.wr16(`T0CI_ADR_CNT_H, `T0CI_ADR_CNT_L, 16'h0100);
        cpu.wr(`T0CI_ADR_CTRL_B, 8'h01);
        idle(30);
        cpu.wr(`T0CI_ADR_CTRL_B, 8'h00);
        cpu.rd16(`T0CI_ADR_CNT_L, `T0CI_ADR_CNT_H, v);
        chk(v < 16'h0030, 1'h1);
        cpu.wr(`T0CI_ADR_CTRL_A, 8'h00);
    endtask
    task automatic t_cap();
        cpu.wr(`T0CI_ADR_MASK, 8'h01);
        pulse(5'h10);
        chk(irq_cp, 1'h1);
        pulse(5'h08);
        chk(irq_cp, 1'h0);
        pulse(5'h10);
        cpu.wr(`T0CI_ADR_FLAGS, 8'h01);
        #1;
        chk(irq_cp, 1'h0);
    endtask
    // Verdict and end of run
    task automatic report_and_stop();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (2) @(posedge clk_i);
        srst_i <= 1'h0;
        t_regs();
        t_sync();
        t_sel();
        t_ext();
        t_cmp();
        t_ctc();
        t_wide();
        t_cap();
        report_and_stop();
    end
    // Watchdog, well past the expected run
    initial begin
        #160000;
        failures++;
        report_and_stop();
    end
endmodule // tb_timer0_control_and_interrupts
